// ### core/eeprom_pkg.sv
package eeprom_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int WRITE_TIME_NS = 5_000_000;
    // Self-timed write cycle, whole core clocks
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

    localparam int PAGE_BYTES = 32;
    localparam int NUM_PAGES = 512;
    localparam int BYTE_AW = 5;
    localparam int PAGE_AW = 9;
    localparam int ARRAY_AW = PAGE_AW + BYTE_AW;
    localparam int BITS_PER_BYTE = 8;

    localparam logic [15:0] PROT_REG_ADDR = 16'hFFFF;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam int PROT_LOCK_BIT = 7;
    localparam int PROT_SEL1_BIT = 4;
    localparam int PROT_SEL0_BIT = 3;
    localparam int PROT_RWEL_BIT = 2;
    localparam int PROT_WEL_BIT = 1;
    localparam logic [7:0] PROT_ZERO_MASK = 8'h61;

    localparam logic [1:0] REGION_NONE = 2'h0;
    localparam logic [1:0] REGION_QUARTER = 2'h1;
    localparam logic [1:0] REGION_HALF = 2'h2;
    localparam logic [1:0] REGION_ALL = 2'h3;
    localparam logic [1:0] SEL_RESET = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_WA1,
        ST_WA0,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_BUSY
    } state_t;

    // Upper quarter, upper half or whole array, by the two select bits
    function automatic logic region_hit(input logic [ARRAY_AW-1:0] a, input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            REGION_NONE: hit = 1'b0;
            REGION_QUARTER: hit = (a[ARRAY_AW-1:ARRAY_AW-2] == 2'h3);
            REGION_HALF: hit = a[ARRAY_AW-1];
            REGION_ALL: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // Sequential reads run through the whole array; the register read restarts at zero
    function automatic logic [15:0] next_read(input logic [15:0] a);
        logic [ARRAY_AW-1:0] nxt;
        nxt = a[ARRAY_AW-1:0] + 14'h0001;
        return (a == PROT_REG_ADDR) ? ADDR_RESET : {2'h0, nxt};
    endfunction

endpackage

// ### core/bus_line_sync.sv
`timescale 1ns/1ps
module bus_line_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= IDLE;
            q_out <= IDLE;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end

endmodule

// ### core/serial_eeprom_bus_slave.sv
`timescale 1ns/1ps
// Operation
// R1: Data changes only while clock low
// R2: Start is falling data, clock high
// R3: Stop is rising data, clock high
// R4: Master stops only after line released
// R5: Release after eight bits, ninth acknowledges
// R6: Acknowledge a matching slave address byte
// R7: Acknowledge every byte when write selected; code acknowledges only the first data byte to the register
// R8: Read: eight bits, release, sample acknowledge
// R9: No acknowledge ends read transmission
// R10: Master stops after withholding read acknowledge
// R11: Top four address bits match type
// R12: Next three bits match select pins
// R13: Last address bit selects read/write
// R14: Mismatch: no acknowledge, back to standby
// R15: Master sends two word address bytes
// R16: Array is 512 pages of 32
// R17: Page from high bits, byte low five
// R18: Protect pin low disables hardware protection
// R19: Pin high plus lock freezes register; code freezes only the lock and select bits, the enable latches still change
// R20: No array write without enable latch
// R21: Four region choices: none, quarter, half, all
// R22: Locked regions and register refuse writes; code still writes the enable latch bits of a locked register
// R23: Protection register sits at top address
// R24: Stop after data starts busy write cycle
// R25: Page write wraps byte field, 32 max
// R26: Region codes map none/quarter/half/all upward
module serial_eeprom_bus_slave #(
    parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5 // Arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic dev_select_bit0_in,
    input wire logic dev_select_bit1_in,
    input wire logic dev_select_bit2_in,
    input wire logic write_protect_in,
    input wire logic [7:0] mem_rdata_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [eeprom_pkg::ARRAY_AW-1:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_we_out,
    output logic busy_out,
    output logic write_enable_latch_out,
    output logic region_protect_sel0_out,
    output logic region_protect_sel1_out,
    output logic protect_lock_enable_out
);
    import eeprom_pkg::*;

    typedef struct packed {
        state_t st;
        state_t nxt;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic mack;
        logic [7:0] wa1;
        logic [15:0] addr;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] pmask;
        logic reg_wr;
        logic [7:0] reg_data;
        logic write_enable_latch;
        logic rwel;
        logic lock;
        logic [1:0] sel;
        logic [31:0] wcnt;
        logic scl_p;
        logic sda_p;
        logic sda_lvl;
        logic sda_oe;
        logic busy;
        logic mem_we;
        logic [ARRAY_AW-1:0] mem_addr;
        logic [7:0] mem_wdata;
    } regs_t;

    localparam regs_t REGS_RESET = '{st: ST_IDLE, nxt: ST_IDLE, addr: ADDR_RESET,
        sel: SEL_RESET, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    localparam logic [3:0] FULL_BYTE = 4'(BITS_PER_BYTE);

    regs_t q;
    regs_t d;
    logic [1:0] rst_sync_q;
    logic rst_sync_b;
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] dsel_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Reset released synchronously so no flop leaves reset on a different edge
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync_q[1];

    bus_line_sync #(
        .WIDTH(6),
        .IDLE(6'h03)
    ) u_pin_sync (
        .clk_in(core_clk_in),
        .rst_b_in(rst_sync_b),
        .d_in({write_protect_in, dev_select_bit2_in, dev_select_bit1_in,
               dev_select_bit0_in, sda_in, scl_in}),
        .q_out(pins_s)
    );
    assign {wp_s, dsel_s, sda_s, scl_s} = pins_s;

    assign scl_rise = scl_s && !q.scl_p;
    assign scl_fall = !scl_s && q.scl_p;
    assign start_det = scl_s && q.scl_p && q.sda_p && !sda_s; // R2
    assign stop_det = scl_s && q.scl_p && !q.sda_p && sda_s; // R3

    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] pins);
        return (b[7:4] == DEV_TYPE_CODE) && (b[3:1] == pins); // R11 R12
    endfunction

    function automatic logic [7:0] prot_byte(input regs_t r);
        logic [7:0] b;
        b = 8'h00;
        b[PROT_LOCK_BIT] = r.lock;
        b[PROT_SEL1_BIT] = r.sel[1];
        b[PROT_SEL0_BIT] = r.sel[0];
        b[PROT_RWEL_BIT] = r.rwel;
        b[PROT_WEL_BIT] = r.write_enable_latch;
        return b;
    endfunction

    function automatic logic [7:0] tx_byte(input regs_t r, input logic [7:0] rdata);
        return (r.addr == PROT_REG_ADDR) ? prot_byte(r) : rdata; // R23
    endfunction

    always_comb begin
        logic [4:0] idx;
        logic [7:0] txb;
        idx = q.wcnt[4:0];
        txb = tx_byte(q, mem_rdata_in);
        d = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        d.mem_we = 1'b0;
        d.mem_addr = q.addr[ARRAY_AW-1:0];
        if (q.st == ST_BUSY) begin
            // Bus ignored and line released for the whole cycle
            d.sda_oe = 1'b0; // R24
            d.wcnt = q.wcnt + 32'h1;
            if (q.wcnt < 32'(PAGE_BYTES)) begin
                d.mem_addr = {q.addr[ARRAY_AW-1:BYTE_AW], idx}; // R17
                d.mem_wdata = q.pbuf[idx];
                d.mem_we = q.pmask[idx] && q.write_enable_latch && !region_hit(d.mem_addr, q.sel); // R20 R21 R26
            end
            if (q.wcnt >= WRITE_CYCLES - 1) begin
                d.st = ST_IDLE;
                d.pmask = '0;
            end
        end else if (start_det) begin
            d.st = ST_DEVADDR;
            d.bit_cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_det) begin
            d.sda_oe = 1'b0;
            d.st = ST_IDLE; // R3
            d.wcnt = 32'h0;
            if (q.st == ST_WDATA && q.reg_wr) begin
                if ((q.reg_data & PROT_ZERO_MASK) == 8'h00) begin
                    d.write_enable_latch = q.reg_data[PROT_WEL_BIT];
                    if (q.write_enable_latch) begin
                        d.rwel = q.reg_data[PROT_RWEL_BIT];
                    end
                    // Pin low lifts the lock; pin high with lock set freezes it
                    if (q.write_enable_latch && q.rwel && !(wp_s && q.lock)) begin // R18 R19 R22
                        d.sel = {q.reg_data[PROT_SEL1_BIT], q.reg_data[PROT_SEL0_BIT]};
                        d.lock = q.reg_data[PROT_LOCK_BIT];
                        d.st = ST_BUSY;
                    end
                end
                d.reg_wr = 1'b0;
            end else if (q.st == ST_WDATA && q.pmask != '0 && q.write_enable_latch) begin
                d.st = ST_BUSY; // R24 R20
            end
        end else begin
            unique case (q.st)
                ST_DEVADDR, ST_WA1, ST_WA0, ST_WDATA: begin
                    if (scl_rise && q.bit_cnt < FULL_BYTE) begin
                        d.shift = {q.shift[6:0], sda_s};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall && q.bit_cnt == FULL_BYTE) begin
                        d.bit_cnt = 4'h0;
                        d.st = ST_ACK;
                        d.sda_oe = 1'b1; // R5 R7
                        d.nxt = ST_WDATA;
                        if (q.st == ST_DEVADDR) begin
                            if (dev_match(q.shift, dsel_s)) begin // R6
                                d.nxt = q.shift[0] ? ST_TX : ST_WA1; // R13
                            end else begin
                                d.st = ST_IDLE; // R14
                                d.sda_oe = 1'b0;
                            end
                        end else if (q.st == ST_WA1) begin
                            d.wa1 = q.shift;
                            d.nxt = ST_WA0;
                        end else if (q.st == ST_WA0) begin
                            d.addr = {q.wa1, q.shift}; // R15 R17
                            d.pmask = '0;
                            d.reg_wr = 1'b0;
                        end else if (q.addr == PROT_REG_ADDR) begin
                            // Only one byte may go to the register
                            if (!q.reg_wr) begin
                                d.reg_wr = 1'b1;
                                d.reg_data = q.shift;
                            end else begin
                                d.st = ST_WDATA;
                                d.sda_oe = 1'b0;
                            end
                        end else begin
                            d.pbuf[q.addr[BYTE_AW-1:0]] = q.shift;
                            d.pmask[q.addr[BYTE_AW-1:0]] = 1'b1;
                            d.addr[BYTE_AW-1:0] = q.addr[BYTE_AW-1:0] + 5'h01; // R25 R16
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0; // R5
                        d.st = q.nxt;
                        d.bit_cnt = 4'h0;
                        if (q.nxt == ST_TX) begin
                            d.shift = txb;
                            d.sda_oe = !txb[7];
                            d.addr = next_read(q.addr);
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise && q.bit_cnt < FULL_BYTE) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bit_cnt == FULL_BYTE) begin
                            d.sda_oe = 1'b0; // R8
                            d.st = ST_MACK;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe = !q.shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        d.mack = !sda_s; // R8
                    end else if (scl_fall) begin
                        d.bit_cnt = 4'h0;
                        if (q.mack) begin
                            d.st = ST_TX;
                            d.shift = txb;
                            d.sda_oe = !txb[7];
                            d.addr = next_read(q.addr);
                        end else begin
                            // Wait for the master's stop, line left released
                            d.st = ST_IDLE; // R9 R10
                        end
                    end
                end
                ST_IDLE, ST_BUSY: begin
                end
            endcase
        end
        d.busy = (d.st == ST_BUSY);
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    assign sda_out = q.sda_lvl;
    assign sda_oe_out = q.sda_oe;
    assign mem_addr_out = q.mem_addr;
    assign mem_wdata_out = q.mem_wdata;
    assign mem_we_out = q.mem_we;
    assign busy_out = q.busy;
    assign write_enable_latch_out = q.write_enable_latch;
    assign region_protect_sel0_out = q.sel[0];
    assign region_protect_sel1_out = q.sel[1];
    assign protect_lock_enable_out = q.lock;

    property p_r1;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        $changed(q.sda_oe) |-> (!q.scl_p || !q.sda_oe);
    endproperty
    a_r1: assert property (p_r1) else $error("data line driven while clock high"); // R1
    property p_r2;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_IDLE && !start_det) |=> (q.st == ST_IDLE && !q.sda_oe);
    endproperty
    a_r2: assert property (p_r2) else $error("left standby without a start"); // R2
    property p_r3;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (stop_det && q.st != ST_BUSY) |=> (q.st inside {ST_IDLE, ST_BUSY}) && !q.sda_oe;
    endproperty
    a_r3: assert property (p_r3) else $error("stop did not end the transfer"); // R3
    property p_r6;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_DEVADDR && !start_det && !stop_det && scl_fall && q.bit_cnt == FULL_BYTE
            && dev_match(q.shift, dsel_s)) |=> q.sda_oe && q.st == ST_ACK;
    endproperty
    a_r6: assert property (p_r6) else $error("matching address not acknowledged"); // R6
    property p_r14;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_DEVADDR && !start_det && !stop_det && scl_fall && q.bit_cnt == FULL_BYTE
            && !dev_match(q.shift, dsel_s)) |=> !q.sda_oe && q.st == ST_IDLE;
    endproperty
    a_r14: assert property (p_r14) else $error("mismatched address acknowledged"); // R14
    property p_r9;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_MACK && scl_fall && !q.mack && !start_det && !stop_det)
            |=> q.st == ST_IDLE ##1 !q.sda_oe;
    endproperty
    a_r9: assert property (p_r9) else $error("read continued without acknowledge"); // R9
    property p_r8;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_MACK && scl_fall && q.mack && !start_det && !stop_det)
            |=> q.st == ST_TX && q.bit_cnt == 4'h0 && q.addr != $past(q.addr);
    endproperty
    a_r8: assert property (p_r8) else $error("next read byte not started"); // R8
    property p_r24;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        q.st == ST_BUSY |-> !q.sda_oe;
    endproperty
    a_r24: assert property (p_r24) else $error("data line driven in write cycle"); // R24
    property p_r25;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.st == ST_WDATA && scl_fall && q.bit_cnt == FULL_BYTE && !start_det && !stop_det
            && q.addr != PROT_REG_ADDR) |=> q.addr[15:5] == $past(q.addr[15:5])
            && q.addr[4:0] == 5'($past(q.addr[4:0]) + 5'h01) && q.sda_oe;
    endproperty
    a_r25: assert property (p_r25) else $error("page byte counter wrong"); // R25
    property p_r20;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        q.mem_we |-> q.write_enable_latch && q.st == ST_BUSY;
    endproperty
    a_r20: assert property (p_r20) else $error("array written without enable latch"); // R20
    property p_r21;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        q.mem_we |-> !region_hit(q.mem_addr, q.sel);
    endproperty
    a_r21: assert property (p_r21) else $error("protected region written"); // R21
    property p_r19;
        @(posedge core_clk_in) disable iff (!rst_sync_b)
        (q.lock && wp_s) |=> q.lock && q.sel == $past(q.sel);
    endproperty
    a_r19: assert property (p_r19) else $error("locked protection changed"); // R19

endmodule

// ### bench/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out,
    output logic res_stb_out,
    output logic res_kind_out,
    output logic [7:0] res_val_out
);
    // Clock stands high between frames; data is released to the pull-up when not sending
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        res_stb_out = 1'b0;
        res_kind_out = 1'b0;
        res_val_out = 8'h00;
    end

    // Data moves mid-low and is sampled just before the fall
    task automatic put_bit(input logic b, output logic s);
        sda_low_out = ~b;
        #50 scl_out = 1'b1;
        #95 s = sda_in;
        #5 scl_out = 1'b0;
        #50;
    endtask

    task automatic post(input logic k, input logic [7:0] v);
        res_kind_out = k;
        res_val_out = v;
        res_stb_out = 1'b1;
        #1 res_stb_out = 1'b0;
    endtask

    // Long release before the rise: the slave may still hold its acknowledge
    task automatic start();
        sda_low_out = 1'b0;
        #100 scl_out = 1'b1;
        #100 sda_low_out = 1'b1;
        #100 scl_out = 1'b0;
        #50;
    endtask

    task automatic stop();
        sda_low_out = 1'b1;
        #50 scl_out = 1'b1;
        #100 sda_low_out = 1'b0;
        #100;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
        post(1'b0, {7'h00, ack});
    endtask

    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(~give_ack, s);
        post(1'b1, b);
    endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import eeprom_pkg::*;
    localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value
    localparam int LIMIT = 60000;
    logic clk, rst_b, scl, m_low, sda_line, wp, oe, sdo, we, busy, write_enable_latch, bl0, bl1, lock;
    logic stb, kind;
    logic [7:0] rval, wdata;
    logic [2:0] sel;
    logic [13:0] maddr;
    logic [7:0] mem [0:16383];
    logic [8:0] exp_q [$];
    logic [31:0] seed;
    int errors, total_checks, cycles;

    // Pull-up line, pulled low by either party
    assign sda_line = ~(m_low | (oe & ~sdo));

    serial_eeprom_bus_slave #(.WRITE_CYCLES(200), .DEV_TYPE_CODE(TYPE_CODE))
        i_serial_eeprom_bus_slave (.core_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
        .sda_in(sda_line), .dev_select_bit0_in(sel[0]), .dev_select_bit1_in(sel[1]),
        .dev_select_bit2_in(sel[2]), .write_protect_in(wp), .mem_rdata_in(mem[maddr]),
        .sda_out(sdo), .sda_oe_out(oe), .mem_addr_out(maddr), .mem_wdata_out(wdata),
        .mem_we_out(we), .busy_out(busy), .write_enable_latch_out(write_enable_latch),
        .region_protect_sel0_out(bl0), .region_protect_sel1_out(bl1),
        .protect_lock_enable_out(lock));

    bus_master_model i_bus_master_model (.sda_in(sda_line), .scl_out(scl), .sda_low_out(m_low),
        .res_stb_out(stb), .res_kind_out(kind), .res_val_out(rval));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check_bit(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic conclude();
        if (exp_q.size() != 0) begin
            errors++;
            $display("mismatch queue expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("mismatch timeout expected finished seen running");
            conclude();
        end
        if (we === 1'b1) mem[maddr] <= wdata;
    end

    always @(posedge stb) begin
        logic [8:0] e;
        if (exp_q.size() == 0) begin
            errors++;
            $display("mismatch note expected queued seen %h", rval);
        end else begin
            e = exp_q.pop_front();
            check_bit("kind", e[8], kind);
            if (e[8]) check_byte("read_data", e[7:0], rval);
            else check_bit("ack", e[0], rval[0]);
        end
    end

    task automatic pins(input logic [2:0] s, input logic w);
        @(posedge clk);
        #2;
        sel = s;
        wp = w;
        repeat (4) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] b, input logic e);
        logic a;
        exp_q.push_back({1'b0, 7'h00, e});
        i_bus_master_model.send_byte(b, a);
    endtask

    task automatic rd(input logic give, input logic [7:0] e);
        logic [7:0] d;
        exp_q.push_back({1'b1, e});
        i_bus_master_model.recv_byte(give, d);
    endtask

    task automatic set_addr(input logic [15:0] a);
        i_bus_master_model.start();
        wr({TYPE_CODE, sel, 1'b0}, 1'b1);
        wr(a[15:8], 1'b1);
        wr(a[7:0], 1'b1);
    endtask

    task automatic wait_idle();
        repeat (8) @(posedge clk);
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
    endtask

    // Second byte to the register must go unanswered
    task automatic reg_write(input logic [7:0] v);
        set_addr(PROT_REG_ADDR);
        wr(v, 1'b1);
        wr(v, 1'b0);
        i_bus_master_model.stop();
        wait_idle();
    endtask

    task automatic page_write(input logic [15:0] a, input int n, input logic take, input int bz);
        logic [13:0] p;
        logic [7:0] nd [32];
        logic seen;
        p = {a[13:5], 5'h00};
        seen = 1'b0;
        for (int i = 0; i < 32; i++) nd[i] = mem[p + 14'(i)];
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            if (take) nd[5'(a[4:0] + i)] = seed[7:0];
            wr(seed[7:0], 1'b1);
        end
        i_bus_master_model.stop();
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            seen = seen | busy;
        end
        if (bz >= 0) check_bit("busy", bz == 1, seen);
        if (bz == 1) begin
            i_bus_master_model.start();
            wr({TYPE_CODE, sel, 1'b0}, 1'b0);
            i_bus_master_model.stop();
        end
        wait_idle();
        for (int i = 0; i < 32; i++) check_byte("mem", nd[i], mem[p + 14'(i)]);
    endtask

    task automatic read_seq(input logic [15:0] a, input int n);
        set_addr(a);
        i_bus_master_model.start();
        wr({TYPE_CODE, sel, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) rd(i < n - 1, mem[a[13:0] + 14'(i)]);
        rd(1'b0, 8'hFF);
        i_bus_master_model.stop();
    endtask

    initial begin
        rst_b = 1'b0;
        sel = 3'h0;
        wp = 1'b0;
        seed = 32'hA1201272;
        for (int i = 0; i < 16384; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
        end
        repeat (3) @(posedge clk);
        #2;
        rst_b = 1'b1;
        repeat (8) @(posedge clk);
        check_bit("wel", 1'b0, write_enable_latch);
        check_bit("lock", 1'b0, lock);
        check_bit("busy", 1'b0, busy);
        done("reset");
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            pins(3'(k), seed[0]);
            i_bus_master_model.start();
            wr({TYPE_CODE, 3'(k), 1'b0}, 1'b1);
            i_bus_master_model.start();
            wr({TYPE_CODE, 3'(k + 1), 1'b0}, 1'b0);
            wr({TYPE_CODE, 3'(k), 1'b0}, 1'b0);
            i_bus_master_model.start();
            wr({TYPE_CODE ^ 4'h8, 3'(k), 1'b0}, 1'b0);
            i_bus_master_model.stop();
        end
        page_write(16'h0123, 2, 1'b0, 0);
        done("select and locked out write");
        reg_write(8'h02);
        check_bit("wel", 1'b1, write_enable_latch);
        page_write(16'h2A5E, 34, 1'b1, 1);
        read_seq(16'h2A5E, 5);
        read_seq(16'h3FFE, 3);
        done("page write and reads");
        for (int c = 0; c < 4; c++) begin
            reg_write(8'h06);
            reg_write({3'h0, 2'(c), 3'h6});
            check_bit("sel0", c[0], bl0);
            check_bit("sel1", c[1], bl1);
            page_write(16'h3000, 1, c < 1, -1);
            page_write(16'h2000, 1, c < 2, -1);
            page_write(16'h0100, 1, c < 3, -1);
        end
        done("regions");
        pins(sel, 1'b1);
        reg_write(8'h8E);
        check_bit("lock", 1'b1, lock);
        reg_write(8'h16);
        check_bit("sel0", 1'b1, bl0);
        page_write(16'h3004, 1, 1'b0, -1);
        pins(sel, 1'b0);
        reg_write(8'h16);
        check_bit("sel1", 1'b1, bl1);
        set_addr(PROT_REG_ADDR);
        i_bus_master_model.start();
        wr({TYPE_CODE, sel, 1'b1}, 1'b1);
        rd(1'b0, 8'h16);
        i_bus_master_model.stop();
        done("protection");
        conclude();
    end
endmodule
